/* cfan_pkg.sv */
// Shared constants for the cooling fan speed controller.
package cfan_pkg;

  // ------------------------------------------------------------------
  // Speeds, in percent of full speed
  // ------------------------------------------------------------------
  localparam logic [7:0] SPEED_OFF  = 8'h00;
  localparam logic [7:0] SPEED_FULL = 8'h64;
  localparam logic [7:0] SPEED_MIN  = 8'h14;

  // ------------------------------------------------------------------
  // Temperature profiles, degrees C, two's complement
  // ------------------------------------------------------------------
  localparam logic signed [7:0] SW_ON_C    = 8'sh28;
  localparam logic signed [7:0] SW_MAX_C   = 8'sh50;
  localparam logic signed [7:0] SW_OFF_C   = 8'sh28;
  localparam logic signed [7:0] CARD_ON_C  = 8'sh28;
  localparam logic signed [7:0] CARD_MAX_C = 8'sh46;
  localparam logic signed [7:0] CARD_OFF_C = 8'sh23;
  localparam logic signed [7:0] SW_LOW_C   = 8'shF6;

  // Output current threshold, percent of nominal.
  localparam logic [7:0] CURR_LIMIT_PCT = 8'h3C;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int    TIMER_W      = 34;
  localparam longint CLK_PERIOD_NS = 4;
  localparam longint MIN_ON_S     = 60;
  localparam longint MIN_ON_CYC   = (MIN_ON_S * 64'd1000000000)
                                    / CLK_PERIOD_NS;
  localparam longint TACH_WIN_MS  = 500;
  localparam longint TACH_WIN_CYC = (TACH_WIN_MS * 64'd1000000)
                                    / CLK_PERIOD_NS;

  localparam int NUM_FANS = 3;

  typedef enum logic [1:0] {
    CURVE_IDLE = 2'b01,
    CURVE_RUN  = 2'b10
  } cfan_curve_state_t;

endpackage

/* cfan_curve_if.sv */
// Carrier between the controller and a temperature curve unit.
interface cfan_curve_if;
  logic signed [7:0] temp;
  logic        [7:0] demand;

  modport ctrl  (output temp, input demand);
  modport curve (input temp, output demand);
endinterface

/* cfan_curve.sv */
// Temperature-to-speed curve with turn-on/turn-off hysteresis.
module cfan_curve #(
  parameter logic signed [7:0] ON_C  = cfan_pkg::SW_ON_C,
  parameter logic signed [7:0] MAX_C = cfan_pkg::SW_MAX_C,
  parameter logic signed [7:0] OFF_C = cfan_pkg::SW_OFF_C
) (
  input wire logic   sys_clk,
  input wire logic   rst_b,
  cfan_curve_if.curve cv
);
  import cfan_pkg::*;

  localparam logic [15:0] SPAN  = 16'(SPEED_FULL - SPEED_MIN);
  localparam logic [15:0] RANGE = 16'(MAX_C - ON_C);

  cfan_curve_state_t stateReg;
  cfan_curve_state_t stateNext;
  logic        [7:0] demandNext;
  logic signed [8:0] diff;
  logic       [15:0] scaled;

  // ------------------------------------------------------------------
  // Hysteresis state
  // ------------------------------------------------------------------
  always_comb begin
    case (stateReg)
      CURVE_IDLE: stateNext = (cv.temp >= ON_C) ? CURVE_RUN : CURVE_IDLE;
      CURVE_RUN:  stateNext = (cv.temp < OFF_C) ? CURVE_IDLE : CURVE_RUN; // R6 R11
      default:    stateNext = CURVE_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg <= CURVE_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ------------------------------------------------------------------
  // Speed demand
  // ------------------------------------------------------------------
  // Between the off and on thresholds a running fan holds minimum speed.
  always_comb begin
    diff   = 9'(cv.temp) - 9'(ON_C);
    scaled = 16'(diff[7:0]) * SPAN / RANGE;
    if (stateNext != CURVE_RUN) begin
      demandNext = SPEED_OFF; // R6
    end else if (cv.temp >= MAX_C) begin
      demandNext = SPEED_FULL; // R5 R10
    end else if (diff[8]) begin
      demandNext = SPEED_MIN; // R11
    end else begin
      demandNext = SPEED_MIN + scaled[7:0]; // R15
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cv.demand <= SPEED_OFF;
    end else begin
      cv.demand <= demandNext;
    end
  end

endmodule // cfan_curve

/* cfan_ctrl.sv */
// Cooling fan speed controller: mixing, heatsink and door/top fans.
//
// Summary of operation
// R1: All fans go to full speed on low switch temperature, DC hold, DC brake, dynamic braking, pre-magnetization or a motor adaptation run;
//     the code lets an enabled fixed speed override this for the heatsink and door/top fans.
// R2: The mixing fan always runs at full speed while powered.
// R3: The heatsink fan takes the larger of its switch temperature and output current demands.
// R4: The heatsink current demand is full speed above the current threshold and off below it.
// R5: The switch temperature demand starts at minimum speed at turn-on and reaches full speed at the maximum threshold.
// R6: The switch temperature demand drops to zero below its turn-off threshold.
// R7: The door/top fan takes the highest of card temperature, switch temperature and current demands.
// R8: The door/top current demand is full speed above the current threshold and off below it.
// R9: The door/top switch temperature demand follows the heatsink profile.
// R10: The card temperature demand runs from minimum speed at turn-on to full speed at its maximum threshold.
// R11: The card temperature demand stays active until the lower turn-off threshold is crossed.
// R12: A fixed-speed setting sets a constant speed, and full fixed speed overrides all else.
// R13: Fans start after power-up and, once started, run for at least the minimum on-time.
// R14: Each fan's tachometer is watched to confirm the fan turns.
// R15: Demands rise linearly between the minimum and maximum temperature thresholds.
// R16: Forcing and minimum on-time combine with demands by maximum unless a fixed speed applies.
module cfan_ctrl #(
  parameter logic [cfan_pkg::TIMER_W-1:0] MIN_ON_CYCLES =
    cfan_pkg::TIMER_W'(cfan_pkg::MIN_ON_CYC),
  parameter logic [cfan_pkg::TIMER_W-1:0] TACH_WIN_CYCLES =
    cfan_pkg::TIMER_W'(cfan_pkg::TACH_WIN_CYC)
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  input  wire logic signed [7:0]              switchTemp,
  input  wire logic signed [7:0]              cardTemp,
  input  wire logic        [7:0]              outCurrentPct,
  input  wire logic                           dcHold,
  input  wire logic                           dcBrake,
  input  wire logic                           dynBrake,
  input  wire logic                           preMagnetize,
  input  wire logic                           motorAdaptationRun,
  input  wire logic                           fixedSpeedEn,
  input  wire logic        [7:0]              fixedSpeed,
  input  wire logic [cfan_pkg::NUM_FANS-1:0]  tachIn,
  output logic             [7:0]              mixSpeed,
  output logic             [7:0]              sinkSpeed,
  output logic             [7:0]              doorSpeed,
  output logic [cfan_pkg::NUM_FANS-1:0]       tachFault
);
  import cfan_pkg::*;

  localparam int FAN_MIX  = 0;
  localparam int FAN_SINK = 1;
  localparam int FAN_DOOR = 2;

  cfan_curve_if swCurve ();
  cfan_curve_if cardCurve ();

  logic             forceFull;
  logic       [7:0] currDemand;
  logic       [7:0] sinkDemand;
  logic       [7:0] doorDemand;
  logic       [7:0] sinkNext;
  logic       [7:0] doorNext;
  logic       [7:0] sinkRaw;
  logic       [7:0] doorRaw;
  logic             sinkStart;
  logic             doorStart;
  logic [TIMER_W-1:0] sinkOnReg;
  logic [TIMER_W-1:0] doorOnReg;
  logic [NUM_FANS-1:0] fanRunning;

  assign swCurve.temp   = switchTemp;
  assign cardCurve.temp = cardTemp;

  // ------------------------------------------------------------------
  // Temperature curves
  // ------------------------------------------------------------------
  // One switch curve feeds both fans since their profiles are identical.
  cfan_curve #(
    .ON_C  (SW_ON_C),
    .MAX_C (SW_MAX_C),
    .OFF_C (SW_OFF_C)
  ) uSwitchCurve (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .cv      (swCurve)
  ); // R5 R9

  cfan_curve #(
    .ON_C  (CARD_ON_C),
    .MAX_C (CARD_MAX_C),
    .OFF_C (CARD_OFF_C)
  ) uCardCurve (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .cv      (cardCurve)
  ); // R10 R11

  // ------------------------------------------------------------------
  // Raw demands
  // ------------------------------------------------------------------
  // At exactly the threshold current the fan stays off.
  always_comb begin
    currDemand = (outCurrentPct > CURR_LIMIT_PCT) ? SPEED_FULL
                                                  : SPEED_OFF; // R4 R8
    sinkRaw = (swCurve.demand > currDemand) ? swCurve.demand
                                            : currDemand; // R3
    doorRaw = sinkRaw;
    if (cardCurve.demand > doorRaw) begin
      doorRaw = cardCurve.demand; // R7
    end
  end

  // ------------------------------------------------------------------
  // Forcing, minimum on-time and fixed speed
  // ------------------------------------------------------------------
  // The on-time floor only lifts a low demand to minimum speed and never
  // lowers a higher one, so it is a plain maximum like the forcing.
  // Fixed speed comes last and wins over forcing too, which lets a user
  // pin the speed; the mixing fan is never affected by it.
  always_comb begin
    forceFull = (switchTemp < SW_LOW_C) || dcHold || dcBrake || dynBrake
                || preMagnetize || motorAdaptationRun; // R1
    sinkDemand = sinkRaw;
    doorDemand = doorRaw;
    if ((sinkOnReg != '0) && (sinkDemand < SPEED_MIN)) begin
      sinkDemand = SPEED_MIN; // R13 R16
    end
    if ((doorOnReg != '0) && (doorDemand < SPEED_MIN)) begin
      doorDemand = SPEED_MIN; // R13 R16
    end
    if (forceFull) begin
      sinkDemand = SPEED_FULL; // R16
      doorDemand = SPEED_FULL;
    end
    if (fixedSpeedEn) begin
      sinkNext = fixedSpeed; // R12
      doorNext = fixedSpeed;
    end else begin
      sinkNext = sinkDemand;
      doorNext = doorDemand;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mixSpeed  <= SPEED_FULL; // R2
      sinkSpeed <= SPEED_OFF;
      doorSpeed <= SPEED_OFF;
    end else begin
      mixSpeed  <= SPEED_FULL; // R2
      sinkSpeed <= sinkNext;
      doorSpeed <= doorNext;
    end
  end

  // ------------------------------------------------------------------
  // Minimum on-time
  // ------------------------------------------------------------------
  // A fan counts as started on the edge where its speed leaves zero, and
  // that edge reloads the timer. Reloading when the timer runs out while
  // the fan still turns would keep a fan with no demand running forever.
  assign sinkStart = (sinkSpeed == SPEED_OFF) && (sinkNext != SPEED_OFF);
  assign doorStart = (doorSpeed == SPEED_OFF) && (doorNext != SPEED_OFF);

  // Timers start loaded so the fans spin up right after power-up.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sinkOnReg <= MIN_ON_CYCLES; // R13
    end else if (sinkStart) begin
      sinkOnReg <= MIN_ON_CYCLES; // R13
    end else if (sinkOnReg != '0) begin
      sinkOnReg <= sinkOnReg - TIMER_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      doorOnReg <= MIN_ON_CYCLES; // R13
    end else if (doorStart) begin
      doorOnReg <= MIN_ON_CYCLES; // R13
    end else if (doorOnReg != '0) begin
      doorOnReg <= doorOnReg - TIMER_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // Tachometer supervision
  // ------------------------------------------------------------------
  assign fanRunning[FAN_MIX]  = (mixSpeed != SPEED_OFF);
  assign fanRunning[FAN_SINK] = (sinkSpeed != SPEED_OFF);
  assign fanRunning[FAN_DOOR] = (doorSpeed != SPEED_OFF);

  // A stopped fan clears its window so each spin-up starts with a full window.
  // The fault is a level held until the next edge or a stop, so a slow
  // reader cannot miss it. Two flip-flops synchronise the pin and a
  // third one remembers the last level to find the rising edge.
  for (genvar i = 0; i < NUM_FANS; i++) begin : gTach
    logic [2:0]         syncReg;
    logic [TIMER_W-1:0] winReg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        syncReg <= 3'h0;
      end else begin
        syncReg <= {syncReg[1:0], tachIn[i]};
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        winReg       <= '0;
        tachFault[i] <= 1'b0;
      end else if (!fanRunning[i]) begin
        winReg       <= '0;
        tachFault[i] <= 1'b0;
      end else if (syncReg[1] && !syncReg[2]) begin
        winReg       <= '0; // R14
        tachFault[i] <= 1'b0;
      end else if (winReg >= TACH_WIN_CYCLES - TIMER_W'(1)) begin
        tachFault[i] <= 1'b1; // R14
      end else begin
        winReg <= winReg + TIMER_W'(1);
      end
    end
  end

endmodule // cfan_ctrl

/* cfan_ctrl_chk.sv */
// Concurrent checks on the cooling fan controller ports.
module cfan_ctrl_chk #(
  parameter logic [cfan_pkg::TIMER_W-1:0] MIN_ON_CYCLES   = 34'h32,
  parameter logic [cfan_pkg::TIMER_W-1:0] TACH_WIN_CYCLES = 34'h14
) (
  input logic       sys_clk,
  input logic       rst_b,
  input logic [7:0] outCurrentPct,
  input logic       dcHold,
  input logic       dcBrake,
  input logic       dynBrake,
  input logic       preMagnetize,
  input logic       motorAdaptationRun,
  input logic       fixedSpeedEn,
  input logic [7:0] fixedSpeed,
  input logic [2:0] tachIn,
  input logic [7:0] mixSpeed,
  input logic [7:0] sinkSpeed,
  input logic [7:0] doorSpeed,
  input logic [2:0] tachFault
);
  import cfan_pkg::*;
  logic        forceAny;
  logic [15:0] upCnt;
  logic [15:0] quietCnt;
  assign forceAny = dcHold | dcBrake | dynBrake | preMagnetize
                    | motorAdaptationRun;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) upCnt <= 16'h0000;
    else if (upCnt != 16'hFFFF) upCnt <= upCnt + 16'h0001;
  end
  // Counted from the raw tach edge, so it leads the synchroniser.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) quietCnt <= 16'h0000;
    else if ($rose(tachIn[1])) quietCnt <= 16'h0000;
    else if (quietCnt != 16'hFFFF) quietCnt <= quietCnt + 16'h0001;
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_mix_full: assert property (
    mixSpeed == SPEED_FULL) else $error("mixing fan not full");
  a_force_full: assert property (
    forceAny && !fixedSpeedEn |=> sinkSpeed == SPEED_FULL
      && doorSpeed == SPEED_FULL) else $error("forcing ignored");
  a_fixed_speed: assert property (
    fixedSpeedEn |=> sinkSpeed == $past(fixedSpeed)
      && doorSpeed == $past(fixedSpeed)) else $error("fixed speed lost");
  a_current_full: assert property (
    outCurrentPct > CURR_LIMIT_PCT && !fixedSpeedEn |=>
      sinkSpeed == SPEED_FULL && doorSpeed == SPEED_FULL)
    else $error("high current ignored");
  a_min_speed: assert property (
    !fixedSpeedEn |=> (sinkSpeed == SPEED_OFF || sinkSpeed >= SPEED_MIN)
      && (doorSpeed == SPEED_OFF || doorSpeed >= SPEED_MIN))
    else $error("speed below minimum");
  a_startup_run: assert property (
    upCnt >= 16'h0001 && upCnt < MIN_ON_CYCLES - 3 && !fixedSpeedEn |=>
      sinkSpeed >= SPEED_MIN && doorSpeed >= SPEED_MIN)
    else $error("startup run too short");
  a_fault_late: assert property (
    $rose(tachFault[1]) |-> quietCnt >= TACH_WIN_CYCLES)
    else $error("tach fault too early");
  a_stop_clear: assert property (
    (sinkSpeed == SPEED_OFF)[*4] |-> !tachFault[1])
    else $error("tach fault on stopped fan");
endmodule // cfan_ctrl_chk

bind cfan_ctrl cfan_ctrl_chk #(
  .MIN_ON_CYCLES(MIN_ON_CYCLES),
  .TACH_WIN_CYCLES(TACH_WIN_CYCLES)
) u_chk (.sys_clk, .rst_b, .outCurrentPct, .dcHold, .dcBrake, .dynBrake,
  .preMagnetize, .motorAdaptationRun, .fixedSpeedEn, .fixedSpeed, .tachIn,
  .mixSpeed, .sinkSpeed, .doorSpeed, .tachFault);

/* cfan_fan_model.sv */
// Fan model: tach pulses from each running fan, with stall control.
module cfan_fan_model #(
  parameter int PER = 8
) (
  input  logic       sys_clk,
  input  logic       rst_b,
  input  logic [7:0] mixSpeed,
  input  logic [7:0] sinkSpeed,
  input  logic [7:0] doorSpeed,
  input  logic [2:0] stall,
  output logic [2:0] tachIn
);
  import cfan_pkg::*;
  int         phase;
  logic [2:0] spin;
  // A stalled rotor gives no edges at all, so its line rests low.
  assign spin = {doorSpeed != SPEED_OFF, sinkSpeed != SPEED_OFF,
                 mixSpeed != SPEED_OFF} & ~stall;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) phase <= 0;
    else phase <= (phase == PER - 1) ? 0 : phase + 1;
  end
  assign tachIn = (phase == 0) ? spin : 3'h0;
endmodule // cfan_fan_model

/* test_cooling_fan_speed_control.sv */
// Self-checking bench for the cooling fan speed controller.
module test_cooling_fan_speed_control;
  timeunit 1ns;
  timeprecision 1ps;
  import cfan_pkg::*;
  localparam int     MIN_ON = 50;
  logic              sys_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic signed [7:0] switchTemp = 8'sh19;
  logic signed [7:0] cardTemp = 8'sh19;
  logic [7:0]        outCurrentPct = 8'h00;
  logic [4:0]        forceVec = 5'h00;
  logic              fixedSpeedEn = 1'b0;
  logic [7:0]        fixedSpeed = 8'h00;
  logic [2:0]        stall = 3'h0;
  logic [2:0]        tachIn, tachFault;
  logic [7:0]        mixSpeed, sinkSpeed, doorSpeed;
  logic [18:0]       expQ[$];
  logic              cardOn = 1'b0;
  int                badCount = 0, nChecks = 0, seed = 65737, i;
  int                tbl[16][3] = '{'{39, 25, 0}, '{40, 25, 0},
    '{60, 25, 0}, '{79, 25, 0}, '{80, 25, 0}, '{-10, 25, 0}, '{-11, 25, 0},
    '{25, 45, 0}, '{25, 38, 0}, '{25, 34, 0}, '{25, 38, 0}, '{25, 70, 0},
    '{25, 25, 61}, '{25, 25, 60}, '{60, 52, 0}, '{45, 60, 0}};
  logic [7:0]        fxv[3] = '{8'h00, 8'h32, 8'h64};
  event              chk;
  always #2 sys_clk = ~sys_clk;
  cfan_ctrl #(.MIN_ON_CYCLES(34'(MIN_ON)), .TACH_WIN_CYCLES(34'h14)) DUT (
    .sys_clk, .rst_b, .switchTemp, .cardTemp, .outCurrentPct,
    .dcHold(forceVec[0]), .dcBrake(forceVec[1]), .dynBrake(forceVec[2]),
    .preMagnetize(forceVec[3]), .motorAdaptationRun(forceVec[4]),
    .fixedSpeedEn, .fixedSpeed, .tachIn, .mixSpeed, .sinkSpeed,
    .doorSpeed, .tachFault);
  cfan_fan_model FAN (.sys_clk, .rst_b, .mixSpeed, .sinkSpeed,
    .doorSpeed, .stall, .tachIn);
  function automatic logic [7:0] crv(int t, int on, int mx, bit act);
    if (!act) return SPEED_OFF;
    if (t >= mx) return SPEED_FULL;
    if (t <= on) return SPEED_MIN;
    return 8'(SPEED_MIN + (t - on) * (SPEED_FULL - SPEED_MIN) / (mx - on));
  endfunction
  task automatic cmpSpeed(logic [7:0] got, logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpFault(logic [2:0] got, logic [2:0] exp);
    cmpSpeed({5'h00, got}, {5'h00, exp});
  endtask
  // ------------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------------
  task automatic apply(int sw, cd, cur, logic [4:0] f, logic en,
                       logic [7:0] fx, logic [2:0] st);
    logic [7:0] sk, dr;
    @(negedge sys_clk);
    switchTemp = 8'(sw);
    cardTemp = 8'(cd);
    outCurrentPct = 8'(cur);
    forceVec = f;
    fixedSpeedEn = en;
    fixedSpeed = fx;
    stall = st;
    cardOn = (cd >= CARD_ON_C) || (cardOn && cd >= CARD_OFF_C);
    sk = crv(sw, SW_ON_C, SW_MAX_C, sw >= SW_ON_C);
    if (cur > CURR_LIMIT_PCT) sk = SPEED_FULL;
    dr = crv(cd, CARD_ON_C, CARD_MAX_C, cardOn);
    if (sk > dr) dr = sk;
    if (f != 5'h00 || sw < SW_LOW_C) {sk, dr} = {SPEED_FULL, SPEED_FULL};
    if (en) {sk, dr} = {fx, fx};
    // Outlast the minimum on-time so a stopping fan has really stopped.
    repeat (MIN_ON + 10) @(negedge sys_clk);
    expQ.push_back({sk, dr, st & {dr != SPEED_OFF, sk != SPEED_OFF, 1'b1}});
    -> chk;
  endtask
  initial begin : watch
    logic [18:0] e;
    forever begin
      @chk;
      e = expQ.pop_front();
      cmpSpeed(mixSpeed, SPEED_FULL);
      cmpSpeed(sinkSpeed, e[18:11]);
      cmpSpeed(doorSpeed, e[10:3]);
      cmpFault(tachFault, e[2:0]);
    end
  end
  task automatic endSim();
    $display("checks %0d, mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    badCount++;
    endSim();
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (10) @(negedge sys_clk);
    expQ.push_back({SPEED_MIN, SPEED_MIN, 3'h0});
    -> chk;
    $display("startup run done");
    for (i = 0; i < 16; i++)
      apply(tbl[i][0], tbl[i][1], tbl[i][2], 5'h00, 1'b0, 8'h00, 3'h0);
    $display("curves and current done");
    for (i = 0; i < 5; i++)
      apply(25, 25, 0, 5'(1 << i), 1'b0, 8'h00, 3'h0);
    for (i = 0; i < 3; i++)
      apply(25, 25, 100, 5'h1F, 1'b1, fxv[i], 3'h0);
    $display("forcing and fixed speed done");
    apply(60, 25, 0, 5'h00, 1'b0, 8'h00, 3'h6);
    apply(25, 25, 0, 5'h00, 1'b0, 8'h00, 3'h6);
    apply(25, 25, 0, 5'h00, 1'b0, 8'h00, 3'h1);
    apply(25, 25, 0, 5'h00, 1'b0, 8'h00, 3'h0);
    $display("tach watch done");
    repeat (8)
      apply({$random(seed)} % 140 - 20, {$random(seed)} % 90,
            {$random(seed)} % 120, 5'h00, 1'b0, 8'h00, 3'h0);
    $display("random mix done");
    @(negedge sys_clk);
    endSim();
  end
endmodule // test_cooling_fan_speed_control
